// [core/ubm_pkg.sv]
// constants, field layouts and carrier types of the user break unit
// assumes one processor clock shared by bus slave and pipeline taps
package ubm_pkg;
   // =====================================================
   // register byte offsets
   localparam logic [7:0] UBM_OFF_CTRL = 8'h00;
   localparam logic [7:0] UBM_OFF_COND_A = 8'h04;
   localparam logic [7:0] UBM_OFF_COND_B = 8'h08;
   localparam logic [7:0] UBM_OFF_ADDR_A = 8'h0C;
   localparam logic [7:0] UBM_OFF_ADDR_B = 8'h10;
   localparam logic [7:0] UBM_OFF_TAG_A = 8'h14;
   localparam logic [7:0] UBM_OFF_TAG_B = 8'h18;
   localparam logic [7:0] UBM_OFF_DATA_B = 8'h1C;
   localparam logic [7:0] UBM_OFF_DMASK_B = 8'h20;
   localparam logic [7:0] UBM_OFF_IRQ_ST = 8'h24;
   localparam logic [7:0] UBM_OFF_IRQ_MASK = 8'h28;
   localparam logic [7:0] UBM_OFF_SAVED = 8'h2C;
   // =====================================================
   // control word fields
   localparam int UBM_CTRL_SEQ = 0;
   localparam int UBM_CTRL_POST_A = 1;
   localparam int UBM_CTRL_POST_B = 2;
   localparam int UBM_CTRL_DATA_B = 3;
   localparam int UBM_CTRL_FLAG_A = 4;
   localparam int UBM_CTRL_FLAG_B = 5;
   // bus-cycle condition fields: [5:4] kind, [3:2] direction, [1:0] size
   localparam int UBM_COND_KIND = 4;
   localparam int UBM_COND_DIR = 2;
   localparam int UBM_COND_SIZE = 0;
   localparam logic [1:0] UBM_KIND_FETCH = 2'h1;
   localparam logic [1:0] UBM_KIND_DATA = 2'h2;
   localparam logic [1:0] UBM_DIR_READ = 2'h1;
   localparam logic [1:0] UBM_DIR_WRITE = 2'h2;
   localparam logic [1:0] UBM_SIZE_ANY = 2'h0;
   localparam logic [1:0] UBM_SIZE_BYTE = 2'h1;
   localparam logic [1:0] UBM_SIZE_WORD = 2'h2;
   localparam logic [1:0] UBM_SIZE_LONG = 2'h3;
   // tag register: [7:0] space tag, [9:8] address mask code, [10] tag ignored
   localparam int UBM_TAG_MASK = 8;
   localparam int UBM_TAG_IGN = 10;
   localparam logic [31:0] UBM_AMASK_10 = 32'h0000_03FF;
   localparam logic [31:0] UBM_AMASK_12 = 32'h0000_0FFF;
   localparam logic [31:0] UBM_AMASK_ALL = 32'hFFFF_FFFF;
   // interrupt status bits
   localparam int UBM_IRQ_HIT_A = 0;
   localparam int UBM_IRQ_HIT_B = 1;
   localparam int UBM_IRQ_TRAP = 2;
   localparam int UBM_IRQ_W = 3;
   // reset value and AHB-Lite response and transfer codes
   localparam logic [31:0] UBM_RST_WORD = 32'h0000_0000;
   localparam logic [1:0] UBM_HRESP_OKAY = 2'h0;
   localparam logic [1:0] UBM_HTRANS_NONSEQ = 2'h2;

   // one processor bus cycle as issued by the pipeline
   typedef struct packed {
      logic valid;
      logic fetch;
      logic write;
      logic [1:0] size;
      logic [31:0] addr;
      logic [7:0] tag;
      logic [31:0] data;
   } ubm_cycle_t;

   // completion of one instruction and what stands next in the pipe
   typedef struct packed {
      logic valid;
      logic is_trap;
      logic next_exc;
      logic next_halt;
      logic next_nmi;
      logic [31:0] next_pc;
   } ubm_retire_t;

   typedef enum logic [1:0] {UBM_PEND_NONE, UBM_PEND_POST, UBM_PEND_DATA} ubm_pend_t;
endpackage

// [core/ubm_break_unit.sv]
// user_break_unit: two-channel break matcher with AHB-Lite registers
// assumes cpu bus cycles and retire reports are synchronous to hclk
`timescale 1ns/10ps
module ubm_break_unit
   import ubm_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic [1:0] hresp,
   input wire ubm_cycle_t cpu_cycle,
   input wire ubm_retire_t cpu_retire,
   output logic break_trap,
   output logic [31:0] saved_return_pointer,
   output logic irq
);
   if (ADDR_W < 6 || ADDR_W > 32) begin : g_chk
      $error("ADDR_W must hold the register map");
   end

   // =====================================================
   // matching
   // one channel hit; fetch cycles are always reads of even addresses
   function automatic logic chan_hit(input logic [15:0] cond, input logic [31:0] ref_addr,
                                     input logic [31:0] tagw, input ubm_cycle_t c,
                                     input logic use_data, input logic [31:0] dref,
                                     input logic [31:0] dmask);
      logic [1:0] kind;
      logic [1:0] dir;
      logic [1:0] sz;
      logic [31:0] am;
      logic [31:0] dm;
      logic ok;
      kind = cond[UBM_COND_KIND +: 2];
      dir = cond[UBM_COND_DIR +: 2];
      sz = cond[UBM_COND_SIZE +: 2];
      ok = c.valid && kind != 2'h0 && dir != 2'h0;
      ok = ok && (c.fetch ? kind[0] : kind[1]);
      ok = ok && (c.write ? (dir[1] && !c.fetch) : dir[0]);
      if (sz != UBM_SIZE_ANY) begin
         ok = ok && (c.size == sz);
      end
      unique case (tagw[UBM_TAG_MASK +: 2])
         2'h0: am = 32'h0;
         2'h1: am = UBM_AMASK_10;
         2'h2: am = UBM_AMASK_12;
         default: am = UBM_AMASK_ALL;
      endcase
      // low address bits dropped by size
      if (!c.fetch) begin
         unique case (c.size)
            UBM_SIZE_WORD: am[0] = 1'b1;
            UBM_SIZE_LONG: am[1:0] = 2'h3;
            default: am[0] = am[0];
         endcase
      end
      // with mask code 0 fetch cycles compare bit 0 as well, so an odd fetch target never matches
      ok = ok && (((c.addr ^ ref_addr) & ~am) == 32'h0);
      ok = ok && (tagw[UBM_TAG_IGN] || c.tag == tagw[7:0]);
      if (use_data && !c.fetch) begin
         dm = ~dmask;
         if (c.size != UBM_SIZE_LONG) begin
            dm[31:16] = 16'h0;
         end
         ok = ok && (((c.data ^ dref) & dm) == 32'h0);
      end
      return ok;
   endfunction

   // =====================================================
   // registers
   logic [31:0] ctrl_q, ctrl_d;
   logic [15:0] cond_a_q, cond_a_d, cond_b_q, cond_b_d;
   logic [31:0] addr_a_q, addr_a_d, addr_b_q, addr_b_d;
   logic [31:0] tag_a_q, tag_a_d, tag_b_q, tag_b_d;
   logic [31:0] data_b_q, data_b_d, dmask_b_q, dmask_b_d;
   logic [UBM_IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
   logic [31:0] saved_q, saved_d;
   logic [31:0] rdata_q, rdata_d;
   logic wr_pend_q, wr_pend_d;
   logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
   logic trap_q, trap_d;
   logic armed_q, armed_d;
   ubm_pend_t pend_q, pend_d;

   logic hit_a, hit_b, raw_a, raw_b, pre_a, pre_b, post_a, post_b;
   logic seq, ev_a, ev_b, addr_ok;
   logic [ADDR_W-1:0] rd_addr;

   assign seq = ctrl_q[UBM_CTRL_SEQ];
   assign raw_a = chan_hit(cond_a_q, addr_a_q, tag_a_q, cpu_cycle, 1'b0, 32'h0, 32'h0);
   assign raw_b = chan_hit(cond_b_q, addr_b_q, tag_b_q, cpu_cycle,
                           ctrl_q[UBM_CTRL_DATA_B], data_b_q, dmask_b_q);
   // in sequential mode B counts only once A was seen in an earlier bus cycle
   assign hit_a = raw_a && !seq;
   assign hit_b = raw_b && (!seq || armed_q);
   assign pre_a = hit_a && cpu_cycle.fetch && !ctrl_q[UBM_CTRL_POST_A];
   assign pre_b = hit_b && cpu_cycle.fetch && !ctrl_q[UBM_CTRL_POST_B];
   assign post_a = hit_a && !pre_a;
   assign post_b = hit_b && !pre_b;
   assign ev_a = hit_a;
   assign ev_b = hit_b;
   assign rd_addr = haddr[ADDR_W-1:0];
   assign addr_ok = (haddr[1:0] == 2'h0);

   // =====================================================
   // break sequencing
   always_comb begin
      armed_d = armed_q;
      pend_d = pend_q;
      trap_d = 1'b0;
      saved_d = saved_q;
      if (!seq) begin
         armed_d = 1'b0;
      end else if (raw_a) begin
         armed_d = 1'b1;
      end
      if (pend_q != UBM_PEND_NONE && cpu_retire.valid) begin
         pend_d = UBM_PEND_NONE;
         if (!(pend_q == UBM_PEND_POST && (cpu_retire.is_trap || cpu_retire.next_nmi)) &&
             !(pend_q == UBM_PEND_DATA && (cpu_retire.next_exc || cpu_retire.next_halt))) begin
            // return to the instruction after the completed one
            trap_d = 1'b1;
            saved_d = cpu_retire.next_pc;
         end
      end
      // pre-execution wins over post, flags untouched
      if (pre_a || pre_b) begin
         trap_d = 1'b1;
         saved_d = cpu_cycle.addr;
         pend_d = UBM_PEND_NONE;
      end else if (post_a || post_b) begin
         pend_d = (post_b && ctrl_q[UBM_CTRL_DATA_B]) ? UBM_PEND_DATA : UBM_PEND_POST;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         armed_q <= 1'b0;
         pend_q <= UBM_PEND_NONE;
         trap_q <= 1'b0;
         saved_q <= UBM_RST_WORD;
      end else begin
         armed_q <= armed_d;
         pend_q <= pend_d;
         trap_q <= trap_d;
         saved_q <= saved_d;
      end
   end

   // =====================================================
   // AHB-Lite slave, zero wait state
   // read data is fetched in the address phase so hrdata comes from a flop
   always_comb begin
      ctrl_d = ctrl_q;
      cond_a_d = cond_a_q;
      cond_b_d = cond_b_q;
      addr_a_d = addr_a_q;
      addr_b_d = addr_b_q;
      tag_a_d = tag_a_q;
      tag_b_d = tag_b_q;
      data_b_d = data_b_q;
      dmask_b_d = dmask_b_q;
      ist_d = ist_q;
      imask_d = imask_q;
      rdata_d = rdata_q;
      wr_pend_d = 1'b0;
      wr_addr_d = wr_addr_q;
      if (wr_pend_q) begin
         unique case (wr_addr_q)
            ADDR_W'(UBM_OFF_CTRL): begin
               ctrl_d[3:0] = hwdata[3:0];
               // flags only cleared by writing zero
               ctrl_d[UBM_CTRL_FLAG_A] = ctrl_q[UBM_CTRL_FLAG_A] & hwdata[UBM_CTRL_FLAG_A];
               ctrl_d[UBM_CTRL_FLAG_B] = ctrl_q[UBM_CTRL_FLAG_B] & hwdata[UBM_CTRL_FLAG_B];
            end
            ADDR_W'(UBM_OFF_COND_A): cond_a_d = hwdata[15:0];
            ADDR_W'(UBM_OFF_COND_B): cond_b_d = hwdata[15:0];
            ADDR_W'(UBM_OFF_ADDR_A): addr_a_d = hwdata;
            ADDR_W'(UBM_OFF_ADDR_B): addr_b_d = hwdata;
            ADDR_W'(UBM_OFF_TAG_A): tag_a_d = {21'h0, hwdata[10:0]};
            ADDR_W'(UBM_OFF_TAG_B): tag_b_d = {21'h0, hwdata[10:0]};
            ADDR_W'(UBM_OFF_DATA_B): data_b_d = hwdata;
            ADDR_W'(UBM_OFF_DMASK_B): dmask_b_d = hwdata;
            ADDR_W'(UBM_OFF_IRQ_ST): ist_d = ist_q & ~hwdata[UBM_IRQ_W-1:0];
            ADDR_W'(UBM_OFF_IRQ_MASK): imask_d = hwdata[UBM_IRQ_W-1:0];
            default: ist_d = ist_d;
         endcase
      end
      // hardware set wins over software clear
      if (ev_a) begin
         ctrl_d[UBM_CTRL_FLAG_A] = 1'b1;
         ist_d[UBM_IRQ_HIT_A] = 1'b1;
      end
      if (ev_b) begin
         ctrl_d[UBM_CTRL_FLAG_B] = 1'b1;
         ist_d[UBM_IRQ_HIT_B] = 1'b1;
      end
      if (trap_q) begin
         ist_d[UBM_IRQ_TRAP] = 1'b1;
      end
      if (hsel && hready && htrans == UBM_HTRANS_NONSEQ) begin
         wr_pend_d = hwrite;
         wr_addr_d = rd_addr;
         rdata_d = 32'h0;
         if (!hwrite && addr_ok) begin
            unique case (rd_addr)
               ADDR_W'(UBM_OFF_CTRL): rdata_d = {26'h0, ctrl_q[5:0]};
               ADDR_W'(UBM_OFF_COND_A): rdata_d = {16'h0, cond_a_q};
               ADDR_W'(UBM_OFF_COND_B): rdata_d = {16'h0, cond_b_q};
               ADDR_W'(UBM_OFF_ADDR_A): rdata_d = addr_a_q;
               ADDR_W'(UBM_OFF_ADDR_B): rdata_d = addr_b_q;
               ADDR_W'(UBM_OFF_TAG_A): rdata_d = tag_a_q;
               ADDR_W'(UBM_OFF_TAG_B): rdata_d = tag_b_q;
               ADDR_W'(UBM_OFF_DATA_B): rdata_d = data_b_q;
               ADDR_W'(UBM_OFF_DMASK_B): rdata_d = dmask_b_q;
               ADDR_W'(UBM_OFF_IRQ_ST): rdata_d = {29'h0, ist_q};
               ADDR_W'(UBM_OFF_IRQ_MASK): rdata_d = {29'h0, imask_q};
               ADDR_W'(UBM_OFF_SAVED): rdata_d = saved_q;
               default: rdata_d = 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= UBM_RST_WORD;
         cond_a_q <= 16'h0;
         cond_b_q <= 16'h0;
         addr_a_q <= UBM_RST_WORD;
         addr_b_q <= UBM_RST_WORD;
         tag_a_q <= UBM_RST_WORD;
         tag_b_q <= UBM_RST_WORD;
         data_b_q <= UBM_RST_WORD;
         dmask_b_q <= UBM_RST_WORD;
         ist_q <= '0;
         imask_q <= '0;
         rdata_q <= UBM_RST_WORD;
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         cond_a_q <= cond_a_d;
         cond_b_q <= cond_b_d;
         addr_a_q <= addr_a_d;
         addr_b_q <= addr_b_d;
         tag_a_q <= tag_a_d;
         tag_b_q <= tag_b_d;
         data_b_q <= data_b_d;
         dmask_b_q <= dmask_b_d;
         ist_q <= ist_d;
         imask_q <= imask_d;
         rdata_q <= rdata_d;
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
      end
   end

   assign hrdata = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp = UBM_HRESP_OKAY;
   assign break_trap = trap_q;
   assign saved_return_pointer = saved_q;
   assign irq = |(ist_q & imask_q);

   // =====================================================
   // checks
   trap_pulse_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         break_trap |-> $past(pre_a) || $past(pre_b) || $past(cpu_retire.valid))
      else $error("trap request without a hit or retire");
   pre_trap_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (pre_a || pre_b) |=> break_trap && saved_return_pointer == $past(cpu_cycle.addr))
      else $error("pre-execution break not taken at fetch address");
   both_flags_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (pre_a && post_b) |=> ctrl_q[UBM_CTRL_FLAG_A] && ctrl_q[UBM_CTRL_FLAG_B]
                              && pend_q == UBM_PEND_NONE)
      else $error("mixed pre and post break lost a flag");
   fetch_write_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (cpu_cycle.fetch && cond_a_q[UBM_COND_DIR +: 2] == UBM_DIR_WRITE) |-> !raw_a)
      else $error("fetch matched a write-only condition");
   trap_suppress_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (pend_q == UBM_PEND_POST && cpu_retire.valid && cpu_retire.is_trap
          && !pre_a && !pre_b) |=> !break_trap)
      else $error("post break taken on trap instruction");
   data_suppress_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (pend_q == UBM_PEND_DATA && cpu_retire.valid
          && (cpu_retire.next_exc || cpu_retire.next_halt) && !pre_a && !pre_b) |=> !break_trap)
      else $error("data break taken before exception or halt");
   data_return_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (pend_q == UBM_PEND_DATA && cpu_retire.valid && !cpu_retire.next_exc
          && !cpu_retire.next_halt && !pre_a && !pre_b)
         |=> break_trap && saved_return_pointer == $past(cpu_retire.next_pc))
      else $error("data break return pointer wrong");
   seq_order_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (seq && raw_b && !armed_q) |=> ctrl_q[UBM_CTRL_FLAG_B] == $past(ctrl_q[UBM_CTRL_FLAG_B])
                                         || $past(wr_pend_q))
      else $error("sequence matched without earlier channel A hit");
   seq_flag_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (seq && !$past(ctrl_q[UBM_CTRL_FLAG_A]) && !$past(wr_pend_q)) |-> !ctrl_q[UBM_CTRL_FLAG_A])
      else $error("sequential mode set flag A");
   flag_sticky_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (ctrl_q[UBM_CTRL_FLAG_B] && !wr_pend_q) |=> ctrl_q[UBM_CTRL_FLAG_B])
      else $error("flag B cleared without a write");
endmodule

// [verif/ubm_cpu_model.sv]
// cpu pipeline stand-in: issues bus cycles and retire reports on request
// assumes the bench calls its tasks only after reset is released
`timescale 1ns/10ps
module ubm_cpu_model
   import ubm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   output ubm_cycle_t cpu_cycle,
   output ubm_retire_t cpu_retire
);
   // ==============================================
   // idle state
   initial begin
      cpu_cycle = '0;
      cpu_retire = '0;
   end
   // ==============================================
   // bus cycles
   // no slot pairs
   // breaks never aim at a branch and its slot, so one cycle per call
   task automatic cyc(input logic f, input logic w, input logic [1:0] sz,
                      input logic [31:0] a, input logic [7:0] t, input logic [31:0] d);
      wait (hresetn === 1'b1);
      @(posedge hclk);
      cpu_cycle <= {1'b1, f, w, sz, a, t, d};
      @(posedge hclk);
      // released write, address, tag and data lines show the inverse so stale values never match by luck
      cpu_cycle <= {1'b0, f, ~w, sz, ~a, ~t, ~d};
   endtask
   // ==============================================
   // retire pulse after a gap, slow or prompt
   task automatic ret(input int gap, input logic trp, input logic ex, input logic hl,
                      input logic nm, input logic [31:0] pc);
      repeat (gap) @(posedge hclk);
      @(posedge hclk);
      cpu_retire <= {1'b1, trp, ex, hl, nm, pc};
      @(posedge hclk);
      cpu_retire <= {1'b0, trp, ex, hl, nm, ~pc};
   endtask
endmodule

// [verif/tb_user_break_match_unit.sv]
// bench top: bus master, queue of expected traps, break scenarios
// assumes the cpu model drives the pipeline taps; hready loops from hreadyout
`timescale 1ns/10ps
module tb_user_break_match_unit
   import ubm_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, break_trap, irq;
   logic [31:0] haddr, hwdata, hrdata, saved, r, a, rnd;
   logic [1:0] htrans, hresp;
   logic [2:0] hsize;
   ubm_cycle_t cpu_cycle;
   ubm_retire_t cpu_retire;
   int err_count = 0;
   int n_compared = 0;
   logic [31:0] exp_q[$];
   logic [31:0] dad[5] = '{32'h123454, 32'h123456, 32'h123456, 32'h123457, 32'h123458};
   logic [1:0] dsz[5] = '{UBM_SIZE_LONG, UBM_SIZE_WORD, UBM_SIZE_BYTE, UBM_SIZE_BYTE,
                          UBM_SIZE_LONG};
   logic [31:0] bad[5] = '{32'hAB000, 32'hABFFE, 32'hAB002, 32'hAC000, 32'hABFFE};
   logic [31:0] bdat[5] = '{32'hA512, 32'hA512, 32'hA513, 32'hA512, 32'hA512};

   ubm_break_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .cpu_cycle(cpu_cycle), .cpu_retire(cpu_retire), .break_trap(break_trap),
      .saved_return_pointer(saved), .irq(irq));
   ubm_cpu_model i_cpu (.hclk(hclk), .hresetn(hresetn), .cpu_cycle(cpu_cycle),
      .cpu_retire(cpu_retire));

   // ==============================================
   // clock and watchdog
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      err_count++;
      results();
   end
   // ==============================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
      n_compared++;
      if (seen !== expv) begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic results();
      if (err_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ahb-lite single word: hold address until hready, then data phase
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= UBM_HTRANS_NONSEQ;
      haddr <= {24'h0, ad};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      bus(1'b1, ad, wd);
   endtask
   task automatic rd(input logic [7:0] ad);
      bus(1'b0, ad, 32'h0);
   endtask
   // bus condition words go last so no break fires on half-set registers
   task automatic cfg(input logic [31:0] ctl, ca, cb, aa, ab, ta, tgb, db);
      wr(UBM_OFF_CTRL, 32'h0);
      wr(UBM_OFF_ADDR_A, aa);
      wr(UBM_OFF_ADDR_B, ab);
      wr(UBM_OFF_TAG_A, ta);
      wr(UBM_OFF_TAG_B, tgb);
      wr(UBM_OFF_DATA_B, db);
      wr(UBM_OFF_DMASK_B, 32'h0);
      wr(UBM_OFF_IRQ_ST, 32'h7);
      wr(UBM_OFF_CTRL, ctl);
      wr(UBM_OFF_COND_A, ca);
      wr(UBM_OFF_COND_B, cb);
   endtask
   task automatic fin();
      repeat (4) @(posedge hclk);
      chk(32'(exp_q.size()), 32'h0);
   endtask
   task automatic chkfl(input logic [1:0] f);
      rd(UBM_OFF_CTRL);
      chk({30'h0, r[UBM_CTRL_FLAG_B], r[UBM_CTRL_FLAG_A]}, {30'h0, f});
   endtask
   task automatic chkst(input logic [2:0] s);
      rd(UBM_OFF_IRQ_ST);
      chk({29'h0, r[2:0]}, {29'h0, s});
   endtask
   task automatic chkirq(input logic e);
      @(negedge hclk);
      chk({31'h0, irq}, {31'h0, e});
   endtask
   // ==============================================
   // reference: every trap pops the expected return pointer
   always @(posedge hclk) begin
      if (break_trap === 1'b1) begin
         if (exp_q.size() == 0) chk(32'h1, 32'h0);
         else chk(saved, exp_q.pop_front());
      end
   end
   // ==============================================
   // scenarios
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rnd = 32'hAB03_4264;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      // reset words, unmapped word at the end, read-only pointer
      for (int i = 0; i < 13; i++) begin
         rd(8'(i * 4));
         chk(r, UBM_RST_WORD);
         chk({30'h0, hresp}, {30'h0, UBM_HRESP_OKAY});
      end
      // pre-execution fetch at a random even address
      rnd = lfsr(rnd);
      a = {rnd[31:1], 1'b0};
      cfg(32'h0, 32'h16, 32'h0, a, 32'h0, 32'h80, 32'h0, 32'h0);
      exp_q.push_back(a);
      i_cpu.cyc(1'b1, 1'b0, UBM_SIZE_WORD, a, 8'h80, rnd);
      fin();
      chkfl(2'b01);
      chkst(3'b101);
      chkirq(1'b0);
      wr(UBM_OFF_IRQ_MASK, 32'h4);
      chkirq(1'b1);
      wr(UBM_OFF_IRQ_ST, 32'h4);
      chkirq(1'b0);
      chkst(3'b001);
      wr(UBM_OFF_SAVED, 32'hFFFF_FFFF);
      rd(UBM_OFF_SAVED);
      chk(r, a);
      // post-execution fetch: trap retire, nmi next, then plain
      cfg(32'h2, 32'h14, 32'h0, 32'h404, 32'h0, 32'h80, 32'h0, 32'h0);
      for (int k = 0; k < 3; k++) begin
         i_cpu.cyc(1'b1, 1'b0, UBM_SIZE_WORD, 32'h404, 8'h80, rnd);
         if (k == 2) exp_q.push_back(32'h406);
         i_cpu.ret(k, k == 0, 1'b0, 1'b0, k == 1, 32'h406);
         fin();
      end
      chkfl(2'b01);
      // fetch with write, odd fetch target: never match
      cfg(32'h0, 32'h1A, 32'h14, 32'h27128, 32'h31415, 32'h80, 32'h70, 32'h0);
      i_cpu.cyc(1'b1, 1'b0, UBM_SIZE_WORD, 32'h27128, 8'h80, rnd);
      i_cpu.cyc(1'b1, 1'b0, UBM_SIZE_WORD, 32'h31414, 8'h70, rnd);
      fin();
      chkfl(2'b00);
      chkst(3'b000);
      // data read, size not compared, address bits per access size
      cfg(32'h0, 32'h24, 32'h0, 32'h123456, 32'h0, 32'h80, 32'h0, 32'h0);
      for (int k = 0; k < 5; k++) begin
         rnd = lfsr(rnd);
         i_cpu.cyc(1'b0, 1'b0, dsz[k], dad[k], 8'h80, rnd);
         if (k < 3) exp_q.push_back(rnd);
         i_cpu.ret(int'(rnd[1:0]), 1'b0, 1'b0, 1'b0, 1'b0, rnd);
         fin();
      end
      chkfl(2'b01);
      // tag ignored, low ten address bits masked
      cfg(32'h0, 32'h24, 32'h0, 32'h5000, 32'h0, 32'h580, 32'h0, 32'h0);
      exp_q.push_back(32'h700);
      i_cpu.cyc(1'b0, 1'b0, UBM_SIZE_BYTE, 32'h53FF, 8'h11, rnd);
      i_cpu.ret(0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h700);
      i_cpu.cyc(1'b0, 1'b0, UBM_SIZE_BYTE, 32'h5400, 8'h80, rnd);
      i_cpu.ret(0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h704);
      fin();
      chkst(3'b101);
      // data write with value on channel B, low 12 address bits masked
      cfg(32'h8, 32'h0, 32'h2A, 32'h0, 32'hABCDE, 32'h0, 32'h270, 32'hA512);
      for (int k = 0; k < 5; k++) begin
         i_cpu.cyc(1'b0, 1'b1, UBM_SIZE_WORD, bad[k], 8'h70, bdat[k]);
         if (k == 4) exp_q.push_back(32'h600);
         i_cpu.ret(1, 1'b0, k == 0, k == 1, 1'b0, 32'h600);
         fin();
      end
      chkfl(2'b10);
      rd(UBM_OFF_SAVED);
      chk(r, 32'h600);
      // pre on A and post on B at one address
      cfg(32'h4, 32'h16, 32'h16, 32'h8010, 32'h8010, 32'h80, 32'h80, 32'h0);
      exp_q.push_back(32'h8010);
      i_cpu.cyc(1'b1, 1'b0, UBM_SIZE_WORD, 32'h8010, 8'h80, rnd);
      i_cpu.ret(0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h8012);
      fin();
      chkfl(2'b11);
      // sequence: B first, then data hit on A, then fetch hit on B
      cfg(32'h1, 32'h2A, 32'h16, 32'h100, 32'h200, 32'h80, 32'h80, 32'h0);
      i_cpu.cyc(1'b1, 1'b0, UBM_SIZE_WORD, 32'h200, 8'h80, rnd);
      i_cpu.cyc(1'b0, 1'b1, UBM_SIZE_WORD, 32'h100, 8'h80, rnd);
      exp_q.push_back(32'h200);
      i_cpu.cyc(1'b1, 1'b0, UBM_SIZE_WORD, 32'h200, 8'h80, rnd);
      fin();
      chkfl(2'b10);
      // sequence with A and B hit in the same bus cycle
      cfg(32'h1, 32'h16, 32'h16, 32'h300, 32'h300, 32'h80, 32'h80, 32'h0);
      i_cpu.cyc(1'b1, 1'b0, UBM_SIZE_WORD, 32'h300, 8'h80, rnd);
      fin();
      chkfl(2'b00);
      results();
   end
endmodule
